// ---- rtl/ssw_supervisor.sv ----
// Supply supervisor: timed reset, manual reset debounce, watchdog, aux fail flag
`timescale 1ns/1ps
module ssw_supervisor #(
  parameter int unsigned TICK_CYCLES    = ssw_pkg::TICK_CYCLES,
  parameter int unsigned RESET_TICKS    = ssw_pkg::RESET_PULSE_MS,
  parameter int unsigned BROWNOUT_TICKS = ssw_pkg::BROWNOUT_MIN_MS,
  parameter int unsigned WATCHDOG_TICKS = ssw_pkg::WATCHDOG_MS,
  parameter int unsigned DEBOUNCE_TICKS = ssw_pkg::DEBOUNCE_MS
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic supply_low_in,
  input  wire logic manual_reset_request_n,
  input  wire logic watchdog_kick_in,
  input  wire logic watchdog_kick_float_in,
  input  wire logic aux_supply_sense_in,
  output logic      reset_out_n,
  output logic      reset_out,
  output logic      open_drain_reset_out,
  output logic      open_drain_reset_oe,
  output logic      watchdog_fault_out_n,
  output logic      aux_supply_fail_out_n
);
  // Timebase: one-cycle tick per millisecond, free running
  logic [ssw_pkg::TICK_W-1:0] tick_cnt_q, tick_cnt_d;
  logic                       tick;

  always_comb begin
    tick       = (tick_cnt_q == ssw_pkg::TICK_W'(TICK_CYCLES - 1));
    tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // Manual reset debounce: input must stay stable for the debounce time
  logic                     mr_raw_q, mr_raw_d;
  logic                     mr_active_q, mr_active_d;
  logic [ssw_pkg::MS_W-1:0] mr_cnt_q, mr_cnt_d;

  always_comb begin
    mr_raw_d    = ~manual_reset_request_n;
    mr_active_d = mr_active_q;
    mr_cnt_d    = mr_cnt_q;
    if (mr_raw_q == mr_active_q) begin
      mr_cnt_d = '0;
    end else if (tick) begin
      if (mr_cnt_q == ssw_pkg::MS_W'(DEBOUNCE_TICKS - 1)) begin
        mr_active_d = mr_raw_q;
        mr_cnt_d    = '0;
      end else begin
        mr_cnt_d = mr_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mr_raw_q    <= 1'b0;
      mr_active_q <= 1'b0;
      mr_cnt_q    <= '0;
    end else begin
      mr_raw_q    <= mr_raw_d;
      mr_active_q <= mr_active_d;
      mr_cnt_q    <= mr_cnt_d;
    end
  end

  // Reset pulse timer; counts down only once supply and button are good
  logic [ssw_pkg::MS_W-1:0] rst_cnt_q, rst_cnt_d;
  logic                     rst_hold;
  logic                     rst_asserted;

  always_comb begin
    rst_hold  = supply_low_in | mr_active_q;
    rst_cnt_d = rst_cnt_q;
    if (rst_hold) begin
      // Reload RESET_TICKS so any new cause restarts the pulse
      rst_cnt_d = ssw_pkg::MS_W'(RESET_TICKS);
      if (supply_low_in && RESET_TICKS < BROWNOUT_TICKS) begin
        // A brownout never gets less than the minimum extension, whatever the pulse setting
        rst_cnt_d = ssw_pkg::MS_W'(BROWNOUT_TICKS);
      end
    end else if (tick && rst_cnt_q != '0) begin
      rst_cnt_d = rst_cnt_q - 1'b1;
    end
    rst_asserted = rst_hold | (rst_cnt_q != '0);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cnt_q <= ssw_pkg::MS_W'(RESET_TICKS);
    end else begin
      rst_cnt_q <= rst_cnt_d;
    end
  end

  // Watchdog
  logic                     kick_q, kick_d;
  logic [ssw_pkg::MS_W-1:0] wd_cnt_q, wd_cnt_d;
  logic                     wd_to_q, wd_to_d;

  always_comb begin
    kick_d   = watchdog_kick_in;
    wd_cnt_d = wd_cnt_q;
    wd_to_d  = wd_to_q;
    if (rst_asserted || watchdog_kick_float_in) begin
      wd_cnt_d = '0;
      wd_to_d  = 1'b0;
    end else if (kick_q != watchdog_kick_in) begin
      wd_cnt_d = '0;
      wd_to_d  = 1'b0;
    end else if (tick && !wd_to_q) begin
      if (wd_cnt_q == ssw_pkg::MS_W'(WATCHDOG_TICKS - 1)) begin
        wd_to_d = 1'b1;
      end else begin
        wd_cnt_d = wd_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      kick_q   <= 1'b0;
      wd_cnt_q <= '0;
      wd_to_q  <= 1'b0;
    end else begin
      kick_q   <= kick_d;
      wd_cnt_q <= wd_cnt_d;
      wd_to_q  <= wd_to_d;
    end
  end

  // Output registers; all reset variants share one source so timing matches
  logic rst_n_d, wdo_n_d, pfo_n_d;

  always_comb begin
    rst_n_d = ~rst_asserted;
    wdo_n_d = ~(wd_to_q | supply_low_in);
    pfo_n_d = aux_supply_sense_in;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reset_out_n           <= 1'b0;
      reset_out             <= 1'b1;
      open_drain_reset_out  <= 1'b0;
      open_drain_reset_oe   <= 1'b1;
      watchdog_fault_out_n  <= 1'b1;
      aux_supply_fail_out_n <= 1'b1;
    end else begin
      reset_out_n           <= rst_n_d;
      reset_out             <= ~rst_n_d;
      open_drain_reset_out  <= 1'b0;
      open_drain_reset_oe   <= ~rst_n_d;
      watchdog_fault_out_n  <= wdo_n_d;
      aux_supply_fail_out_n <= pfo_n_d;
    end
  end
endmodule : ssw_supervisor

// ---- common/ssw_pkg.sv ----
// Constants for the supply supervisor watchdog
// Contract
// - Debounced active-low manual reset starts pulse
// - Reset low while supply below threshold
// - Hold reset 200 ms after supply good
// - Supply dip below threshold asserts reset
// - Brownout mid-pulse extends at least 140 ms
// - Power-down keeps reset asserted
// - Active-high reset is inverse output
// - Open-drain reset only pulls low
// - No kick within 1.6 s drives fault low
// - Timer cleared during reset or float
// - Timer counts after release with driven kick
// - Floating kick disables watchdog
// - Undervoltage drives watchdog output low
// - Reset asserted together with undervoltage fault
// - Aux fail output low when sense low
package ssw_pkg;
  localparam int unsigned CLK_HZ           = 200_000_000;
  localparam int unsigned TICK_US          = 1_000;
  localparam int unsigned TICK_CYCLES      = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned RESET_PULSE_MS   = 200;
  localparam int unsigned BROWNOUT_MIN_MS  = 140;
  localparam int unsigned WATCHDOG_MS      = 1_600;
  localparam int unsigned DEBOUNCE_MS      = 20;
  localparam int unsigned TICK_W           = 18;
  localparam int unsigned MS_W             = 11;
endpackage : ssw_pkg

// ---- verif/ssw_chk.sv ----
// Port assertions for the supply supervisor
`timescale 1ns/1ps
module ssw_chk (
  input wire logic sys_clk,
  sys_rst,
  supply_low_in,
  manual_reset_request_n,
  watchdog_kick_in,
  watchdog_kick_float_in,
  aux_supply_sense_in,
  reset_out_n,
  reset_out,
  open_drain_reset_out,
  open_drain_reset_oe,
  watchdog_fault_out_n,
  aux_supply_fail_out_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence manual_held;
    !manual_reset_request_n [*8] ##1 !manual_reset_request_n [*8];
  endsequence
  sequence kick_seen;
    $changed(watchdog_kick_in) && !watchdog_kick_float_in && !supply_low_in ##1 !supply_low_in;
  endsequence
  low_trip_a: assert property (supply_low_in |=> !reset_out_n && !watchdog_fault_out_n)
    else $error("no trip");
  hold_rst_a: assert property ($fell(supply_low_in) |-> !reset_out_n [*8])
    else $error("short pulse");
  inv_rst_a: assert property (reset_out == !reset_out_n)
    else $error("high reset");
  od_rst_a: assert property (open_drain_reset_oe == !reset_out_n && !open_drain_reset_out)
    else $error("drain pin");
  aux_flag_a: assert property (1'b1 |=> aux_supply_fail_out_n == $past(aux_supply_sense_in))
    else $error("aux flag");
  manual_rst_a: assert property (manual_held |-> !reset_out_n)
    else $error("manual");
  float_idle_a: assert property (watchdog_kick_float_in [*2] ##0 watchdog_fault_out_n && !supply_low_in |=> watchdog_fault_out_n)
    else $error("float");
  kick_clear_a: assert property (kick_seen |=> watchdog_fault_out_n)
    else $error("kick");
  rst_wd_idle_a: assert property (!reset_out_n && !supply_low_in |=> watchdog_fault_out_n)
    else $error("watchdog counted in reset");
endmodule : ssw_chk
bind ssw_supervisor ssw_chk ssw_chk_i (.*);

// ---- verif/ssw_cpu.sv ----
// Processor model that kicks the watchdog or releases the pin
`timescale 1ns/1ps
module ssw_cpu (
  input wire logic [7:0] period,
  input wire logic sys_clk,
  hiz,
  output logic watchdog_kick_in = 1'b0,
  watchdog_kick_float_in = 1'b0
);
  logic [7:0] gap_q = 8'h00;
  // A released pin toggles every cycle, so a design still counting it sees a kick each cycle
  always @(posedge sys_clk) begin
    gap_q <= (gap_q >= period) ? 8'h00 : gap_q + 8'h01;
    watchdog_kick_float_in <= hiz;
    if (hiz || (period != 8'h00 && gap_q == period)) watchdog_kick_in <= ~watchdog_kick_in;
  end
endmodule : ssw_cpu

// ---- verif/ssw_supervisor_test.sv ----
// Bench for the supply supervisor
`timescale 1ns/1ps
module ssw_supervisor_test;
  logic sys_clk = 0, sys_rst = 1, supply_low_in = 0, manual_reset_request_n = 1, hiz = 0, aux_supply_sense_in = 1;
  logic aux_exp, reset_out_n, reset_out, open_drain_reset_out, open_drain_reset_oe, aux_supply_fail_out_n;
  logic watchdog_kick_in, watchdog_kick_float_in, watchdog_fault_out_n;
  logic [7:0] period = 8'h04;
  int n_mismatch = 0, checks = 0, cyc = 0, n, seed = 32'hCCDD;
  always #2.5 sys_clk = ~sys_clk;
  ssw_cpu ssw_cpu_i (.*);
  ssw_supervisor #(.TICK_CYCLES(4), .RESET_TICKS(5), .BROWNOUT_TICKS(3), .WATCHDOG_TICKS(8), .DEBOUNCE_TICKS(2))
    ssw_supervisor_i (.*);
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %h %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // Cycles until reset lets go or the watchdog fires; ticks make it coarse
  task automatic span(bit wd, int lo, int hi);
    n = 0;
    while ((wd ? watchdog_fault_out_n !== 1'b0 : reset_out_n !== 1'b1) && n < 99) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n >= lo && n <= hi, 1);
  endtask : span
  task automatic dip();
    @(posedge sys_clk) supply_low_in <= 1;
    @(posedge sys_clk) supply_low_in <= 0;
    @(negedge sys_clk);
    chk({reset_out_n, watchdog_fault_out_n}, 0);
  endtask : dip
  always @(posedge sys_clk) begin
    cyc++;
    aux_supply_sense_in <= 1'($random(seed));
    aux_exp <= aux_supply_sense_in;
    if (cyc == 4000) begin
      n_mismatch++;
      finish_test();
    end
  end
  always @(negedge sys_clk) if (cyc > 10) chk(aux_supply_fail_out_n, aux_exp);
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 0;
    @(negedge sys_clk);
    span(0, 16, 24);
    dip();
    span(0, 16, 24);
    dip();
    repeat (8) @(negedge sys_clk);
    dip();
    span(0, 16, 24);
    @(posedge sys_clk) manual_reset_request_n <= 0;
    repeat (16) @(negedge sys_clk);
    chk({reset_out_n, reset_out, open_drain_reset_oe, open_drain_reset_out}, 4'h6);
    @(posedge sys_clk) manual_reset_request_n <= 1;
    span(0, 16, 38);
    repeat (30) @(negedge sys_clk);
    @(posedge sys_clk) period <= 8'h00;
    span(1, 27, 40);
    @(posedge sys_clk) period <= 8'h04;
    repeat (12) @(negedge sys_clk);
    @(posedge sys_clk) hiz <= 1;
    repeat (60) @(negedge sys_clk);
    chk(watchdog_fault_out_n, 1);
    dip();
    finish_test();
  end
endmodule : ssw_supervisor_test
